// >>> sleep_pkg.sv
// Package for the sleep-mode controller: mode codes, field positions,
// timing constants and states shared by the controller and its helpers.
// Assumes a single 100 MHz clock domain.
package sleep_pkg;
	// Clock period in ns
	localparam int CLK_PERIOD_NS = 10;
	// Control byte field positions
	localparam int SLEEP_EN_POS = 5;
	localparam int MODE_LO_HI = 4;
	localparam int MODE_LO_LO = 3;
	localparam int MODE_HI_POS = 2;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// Mode-select codes
	localparam logic [2:0] MODE_IDLE = 3'h0;
	localparam logic [2:0] MODE_ADC_NR = 3'h1;
	localparam logic [2:0] MODE_PDOWN = 3'h2;
	localparam logic [2:0] MODE_PSAVE = 3'h3;
	localparam logic [2:0] MODE_STANDBY = 3'h6;
	localparam logic [2:0] MODE_EXT_STANDBY = 3'h7;
	// Extra halt after start-up, in cycles
	localparam int HALT_CYCLES = 4;
	// Fast wake from the standby modes, in clock cycles
	localparam int STANDBY_WAKE_CYCLES = 6;
	// Default oscillator start-up time in ns
	localparam int STARTUP_NS_DEFAULT = 1000;
	localparam int STARTUP_CYC_DEFAULT =
		(STARTUP_NS_DEFAULT + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Controller states
	typedef enum logic [2:0] {
		ST_RUN,
		ST_SLEEP,
		ST_STARTUP,
		ST_HALT,
		ST_RESUME
	} sleep_state_t;
endpackage

// >>> wake_counter.sv
// Down counter used for the start-up delay and the extra halt cycles.
// Assumes a load pulse and a synchronous active high reset.
`timescale 1ns/10ps
module wake_counter #(
	parameter int WIDTH = 16
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_load,
	input wire logic [WIDTH-1:0] i_count,
	output logic o_done
);
	// Remaining cycles
	logic [WIDTH-1:0] cnt_reg;
	// Busy flag, so done is not seen before a load
	logic busy_reg;

	initial begin
		if (WIDTH < 4) begin
			$error("wake_counter WIDTH too small");
		end
	end

	// Count down after load
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt_reg <= '0;
			busy_reg <= 1'b0;
		end else if (i_load) begin
			cnt_reg <= i_count;
			busy_reg <= 1'b1;
		end else if (busy_reg && cnt_reg != '0) begin
			cnt_reg <= cnt_reg - 1'b1;
		end else begin
			busy_reg <= 1'b0;
		end
	end

	// Done when the count has run out, one cycle wide
	assign o_done = busy_reg && (cnt_reg == '0);
endmodule

// >>> wake_qualifier.sv
// Decides per sleep mode which wake-up sources may end the sleep.
// Assumes every source input is a level or pulse on the main clock.
`timescale 1ns/10ps
module wake_qualifier
	import sleep_pkg::*;
(
	input wire logic [2:0] i_mode,
	input wire logic i_async_timer_clock_select,
	input wire logic i_global_irq_en,
	input wire logic i_timer0_irq,
	input wire logic i_timer0_irq_en,
	input wire logic i_adc_done_irq,
	input wire logic i_twi_match_irq,
	input wire logic i_spm_ee_ready_irq,
	input wire logic i_level_irq_pins_high,
	input wire logic i_ext_irq_pins_low,
	input wire logic i_other_irq,
	output logic o_wake_irq
);
	// Timer 0 wake only with its enable and the global enable
	logic t0_ok;
	logic t0_async_ok;
	assign t0_ok = i_timer0_irq && i_timer0_irq_en && i_global_irq_en;
	// In the power-save family the timer runs only when async clocked
	assign t0_async_ok = t0_ok && i_async_timer_clock_select;

	// Per mode source filter
	always_comb begin
		o_wake_irq = 1'b0;
		unique case (i_mode)
			MODE_IDLE: begin
				o_wake_irq = i_adc_done_irq | i_twi_match_irq | t0_ok
					| i_spm_ee_ready_irq | i_level_irq_pins_high
					| i_ext_irq_pins_low | i_other_irq;
			end
			MODE_ADC_NR: begin
				o_wake_irq = i_adc_done_irq | i_twi_match_irq | t0_ok
					| i_spm_ee_ready_irq | i_level_irq_pins_high
					| i_ext_irq_pins_low;
			end
			MODE_PDOWN, MODE_STANDBY: begin
				o_wake_irq = i_twi_match_irq | i_level_irq_pins_high
					| i_ext_irq_pins_low;
			end
			MODE_PSAVE, MODE_EXT_STANDBY: begin
				o_wake_irq = i_twi_match_irq | i_level_irq_pins_high
					| i_ext_irq_pins_low | t0_async_ok;
			end
			default: begin
				// Reserved codes never sleep, so nothing to qualify
				o_wake_irq = 1'b0;
			end
		endcase
	end
endmodule

// >>> sleep_mode_controller.sv
// Sleep-mode controller: takes the sleep instruction from the core,
// gates the clock domains per mode and sequences the wake-up.
// Assumes the core holds its state while o_cpu_hold is high and that
// reset sources arrive as synchronous levels.
`timescale 1ns/10ps
module sleep_mode_controller
	import sleep_pkg::*;
#(
	parameter int STARTUP_W = 16,
	parameter int STARTUP_CYC = STARTUP_CYC_DEFAULT
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_mcu_control_reg,
	input wire logic i_sleep_instr,
	input wire logic i_ext_crystal,
	input wire logic [STARTUP_W-1:0] i_clock_select_fuses_cycles,
	input wire logic i_async_timer_clock_select,
	input wire logic i_global_irq_en,
	input wire logic i_timer0_irq,
	input wire logic i_timer0_irq_en,
	input wire logic i_adc_done_irq,
	input wire logic i_twi_match_irq,
	input wire logic i_spm_ee_ready_irq,
	input wire logic i_level_irq_pins_high,
	input wire logic i_ext_irq_pins_low,
	input wire logic i_other_irq,
	input wire logic i_ext_reset,
	input wire logic i_wdt_reset,
	input wire logic i_bod_reset,
	input wire logic i_adc_enable,
	input wire logic i_comparator_disable_bit,
	input wire logic i_comparator_uses_ref,
	input wire logic i_wdt_enable,
	input wire logic i_brownout_enable_fuse,
	input wire logic i_wake_pin_needed,
	output logic o_cpu_hold,
	output logic o_cpu_clock_en,
	output logic o_flash_clock_en,
	output logic o_io_clock_en,
	output logic o_converter_clock_en,
	output logic o_async_clock_en,
	output logic o_osc_en,
	output logic o_adc_start,
	output logic o_adc_extended,
	output logic o_adc_power,
	output logic o_comparator_power,
	output logic o_vref_en,
	output logic o_wdt_run,
	output logic o_bod_run,
	output logic o_input_buf_en,
	output logic o_irq_take,
	output logic o_reset_vector,
	output logic o_sleeping
);
	// Controller state
	sleep_state_t state_reg;
	sleep_state_t state_next;
	// Mode latched at sleep entry
	logic [2:0] mode_reg;
	// Decoded fields of the control byte
	logic sleep_enable_bit;
	logic [2:0] mode_select_bits;
	// Wake sources after per-mode filtering
	logic wake_irq;
	logic any_reset;
	// Counter control
	logic cnt_load;
	logic [STARTUP_W-1:0] cnt_value;
	logic cnt_done;
	// Previous converter enable, to spot an off-on cycle
	logic adc_en_prev_reg;
	// Registered outputs
	logic cpu_clk_reg;
	logic flash_clk_reg;
	logic io_clk_reg;
	logic conv_clk_reg;
	logic async_clk_reg;
	logic osc_reg;
	logic adc_start_reg;
	logic adc_ext_reg;
	logic comp_reg;
	logic vref_reg;
	logic inbuf_reg;
	logic irq_take_reg;
	logic rst_vec_reg;

	initial begin
		if (STARTUP_W < 4 || STARTUP_CYC < 1) begin
			$error("sleep_mode_controller start-up settings invalid");
		end
	end

	// True for codes that name a real mode on this configuration
	function automatic logic mode_valid(input logic [2:0] m,
		input logic xtal);
		unique case (m)
			MODE_IDLE, MODE_ADC_NR, MODE_PDOWN, MODE_PSAVE: begin
				mode_valid = 1'b1;
			end
			MODE_STANDBY, MODE_EXT_STANDBY: begin
				mode_valid = xtal;
			end
			default: begin
				mode_valid = 1'b0;
			end
		endcase
	endfunction

	// True for the modes that stop the I/O and converter clocks
	function automatic logic deep_mode(input logic [2:0] m);
		deep_mode = (m != MODE_IDLE) && (m != MODE_ADC_NR);
	endfunction

	// Field extraction from the control byte
	assign sleep_enable_bit = i_mcu_control_reg[SLEEP_EN_POS];
	assign mode_select_bits = {i_mcu_control_reg[MODE_HI_POS],
		i_mcu_control_reg[MODE_LO_HI:MODE_LO_LO]};
	assign any_reset = i_ext_reset | i_wdt_reset | i_bod_reset;

	wake_qualifier u_qual (
		.i_mode(mode_reg),
		.i_async_timer_clock_select(i_async_timer_clock_select),
		.i_global_irq_en(i_global_irq_en),
		.i_timer0_irq(i_timer0_irq),
		.i_timer0_irq_en(i_timer0_irq_en),
		.i_adc_done_irq(i_adc_done_irq),
		.i_twi_match_irq(i_twi_match_irq),
		.i_spm_ee_ready_irq(i_spm_ee_ready_irq),
		.i_level_irq_pins_high(i_level_irq_pins_high),
		.i_ext_irq_pins_low(i_ext_irq_pins_low),
		.i_other_irq(i_other_irq),
		.o_wake_irq(wake_irq)
	);

	wake_counter #(
		.WIDTH(STARTUP_W)
	) u_cnt (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_load(cnt_load),
		.i_count(cnt_value),
		.o_done(cnt_done)
	);

	// Next state and counter loading
	always_comb begin
		state_next = state_reg;
		cnt_load = 1'b0;
		cnt_value = '0;
		unique case (state_reg)
			ST_RUN: begin
				// Enable clear or reserved code: instruction is a no-op
				if (i_sleep_instr && sleep_enable_bit &&
					mode_valid(mode_select_bits, i_ext_crystal)) begin
					state_next = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (any_reset) begin
					state_next = ST_RUN;
				end else if (wake_irq) begin
					state_next = ST_STARTUP;
					cnt_load = 1'b1;
					if (mode_reg == MODE_STANDBY ||
						mode_reg == MODE_EXT_STANDBY) begin
						// Oscillator still runs, so only a short wait
						cnt_value = STARTUP_W'(STANDBY_WAKE_CYCLES
							- HALT_CYCLES - 1);
					end else if (deep_mode(mode_reg)) begin
						// Fuse-chosen start-up, default only when the fuses read zero
						cnt_value = (i_clock_select_fuses_cycles != '0) ?
							i_clock_select_fuses_cycles :
							STARTUP_W'(STARTUP_CYC);
					end else begin
						cnt_value = '0;
					end
				end
			end
			ST_STARTUP: begin
				if (any_reset) begin
					state_next = ST_RUN;
				end else if (cnt_done) begin
					state_next = ST_HALT;
					cnt_load = 1'b1;
					cnt_value = STARTUP_W'(HALT_CYCLES - 1);
				end
			end
			ST_HALT: begin
				if (any_reset) begin
					state_next = ST_RUN;
				end else if (cnt_done) begin
					state_next = ST_RESUME;
				end
			end
			ST_RESUME: begin
				state_next = ST_RUN;
			end
		endcase
	end

	// State register
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_reg <= ST_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// Mode is latched at entry so later writes cannot change the sleep
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			mode_reg <= MODE_IDLE;
		end else if (state_reg == ST_RUN && state_next == ST_SLEEP) begin
			mode_reg <= mode_select_bits;
		end
	end

	// Mode that holds during the coming sleep cycle
	function automatic logic [2:0] mode_next_sel();
		mode_next_sel = (state_reg == ST_RUN) ? mode_select_bits :
			mode_reg;
	endfunction

	// Clock gating per mode; only clocks are stopped, never storage
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cpu_clk_reg <= 1'b1;
			flash_clk_reg <= 1'b1;
			io_clk_reg <= 1'b1;
			conv_clk_reg <= 1'b1;
			async_clk_reg <= 1'b1;
			osc_reg <= 1'b1;
		end else if (state_next == ST_SLEEP) begin
			// Core and flash stop in every mode; state is held
			cpu_clk_reg <= 1'b0;
			flash_clk_reg <= 1'b0;
			io_clk_reg <= (mode_next_sel() == MODE_IDLE);
			conv_clk_reg <= !deep_mode(mode_next_sel());
			async_clk_reg <= !deep_mode(mode_next_sel()) ||
				((mode_next_sel() == MODE_PSAVE ||
				mode_next_sel() == MODE_EXT_STANDBY) &&
				i_async_timer_clock_select);
			osc_reg <= !deep_mode(mode_next_sel()) ||
				mode_next_sel() == MODE_STANDBY ||
				mode_next_sel() == MODE_EXT_STANDBY;
		end else begin
			cpu_clk_reg <= 1'b1;
			flash_clk_reg <= 1'b1;
			io_clk_reg <= 1'b1;
			conv_clk_reg <= 1'b1;
			async_clk_reg <= 1'b1;
			osc_reg <= 1'b1;
		end
	end

	// Conversion start on entry to the quiet modes
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			adc_start_reg <= 1'b0;
		end else begin
			adc_start_reg <= state_reg == ST_RUN &&
				state_next == ST_SLEEP && i_adc_enable &&
				!deep_mode(mode_select_bits);
		end
	end

	// An off-on cycle of the converter asks for an extended conversion
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			adc_en_prev_reg <= 1'b0;
			adc_ext_reg <= 1'b1;
		end else begin
			adc_en_prev_reg <= i_adc_enable;
			if (i_adc_enable && !adc_en_prev_reg) begin
				adc_ext_reg <= 1'b1;
			end else if (adc_start_reg) begin
				adc_ext_reg <= 1'b0;
			end
		end
	end

	// Analog power: comparator, reference and input buffers
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			comp_reg <= 1'b0;
			vref_reg <= 1'b0;
			inbuf_reg <= 1'b1;
		end else begin
			// Deep modes drop the comparator unless it feeds from vref
			comp_reg <= !i_comparator_disable_bit &&
				(state_next != ST_SLEEP || !deep_mode(mode_next_sel())
				|| i_comparator_uses_ref);
			// Reference follows its users; it needs its own start-up
			vref_reg <= i_brownout_enable_fuse || i_adc_enable ||
				(!i_comparator_disable_bit &&
				i_comparator_uses_ref);
			inbuf_reg <= !(state_next == ST_SLEEP &&
				deep_mode(mode_next_sel()));
		end
	end

	// Handler entry pulse and reset vector pulse
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			irq_take_reg <= 1'b0;
			rst_vec_reg <= 1'b0;
		end else begin
			irq_take_reg <= (state_reg == ST_HALT) &&
				(state_next == ST_RESUME);
			rst_vec_reg <= (state_reg != ST_RUN) &&
				(state_reg != ST_RESUME) && any_reset;
		end
	end

	assign o_cpu_hold = (state_reg != ST_RUN);
	assign o_cpu_clock_en = cpu_clk_reg;
	assign o_flash_clock_en = flash_clk_reg;
	assign o_io_clock_en = io_clk_reg;
	assign o_converter_clock_en = conv_clk_reg;
	assign o_async_clock_en = async_clk_reg;
	assign o_osc_en = osc_reg;
	assign o_adc_start = adc_start_reg;
	assign o_adc_extended = adc_ext_reg;
	// Converter keeps its enable in every mode
	assign o_adc_power = i_adc_enable;
	assign o_comparator_power = comp_reg;
	assign o_vref_en = vref_reg;
	// Watchdog and brown-out are never gated by sleep
	assign o_wdt_run = i_wdt_enable;
	assign o_bod_run = i_brownout_enable_fuse;
	// Wake pins keep their buffers even in deep modes
	assign o_input_buf_en = inbuf_reg || i_wake_pin_needed;
	assign o_irq_take = irq_take_reg;
	assign o_reset_vector = rst_vec_reg;
	assign o_sleeping = (state_reg == ST_SLEEP);
endmodule

// >>> sleep_props.sv
// Checker for the sleep-mode controller, watching its top ports only.
// Assumes one clock domain with a synchronous active high reset.
`timescale 1ns/10ps
module sleep_props
	import sleep_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_mcu_control_reg,
	input wire logic i_sleep_instr,
	input wire logic i_ext_reset,
	input wire logic i_wdt_reset,
	input wire logic i_bod_reset,
	input wire logic i_adc_enable,
	input wire logic i_comparator_uses_ref,
	input wire logic i_wdt_enable,
	input wire logic i_brownout_enable_fuse,
	input wire logic i_wake_pin_needed,
	input wire logic o_cpu_hold,
	input wire logic o_cpu_clock_en,
	input wire logic o_flash_clock_en,
	input wire logic o_io_clock_en,
	input wire logic o_converter_clock_en,
	input wire logic o_async_clock_en,
	input wire logic o_osc_en,
	input wire logic o_adc_power,
	input wire logic o_comparator_power,
	input wire logic o_wdt_run,
	input wire logic o_bod_run,
	input wire logic o_input_buf_en,
	input wire logic o_reset_vector,
	input wire logic o_sleeping
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	// Mode code gathered from its split field positions
	wire [2:0] md = {i_mcu_control_reg[2], i_mcu_control_reg[4:3]};
	// Any of the three reset sources
	wire rst_any = i_ext_reset | i_wdt_reset | i_bod_reset;
	// Asleep with both I/O and converter clocks stopped
	wire deep = o_sleeping & ~o_io_clock_en & ~o_converter_clock_en;
	wire go = i_sleep_instr & ~o_cpu_hold & ~rst_any;

	no_enable_a: assert property (go && !i_mcu_control_reg[5] |=> !o_cpu_hold)
		else $error("Sleep taken with enable clear");
	idle_entry_a: assert property (go && i_mcu_control_reg[5] && md == MODE_IDLE |=> o_sleeping && !o_cpu_clock_en && !o_flash_clock_en && o_io_clock_en && o_converter_clock_en)
		else $error("Idle entry clocks wrong");
	noise_clocks_a: assert property ($rose(o_sleeping) && md == MODE_ADC_NR |-> !o_io_clock_en && o_converter_clock_en && !o_cpu_clock_en)
		else $error("Noise mode clocks wrong");
	pdown_clocks_a: assert property ($rose(o_sleeping) && md == MODE_PDOWN |-> !o_osc_en && !o_async_clock_en && !o_converter_clock_en)
		else $error("Power-down clocks wrong");
	standby_osc_a: assert property ($rose(o_sleeping) && md == MODE_STANDBY |-> o_osc_en && !o_async_clock_en)
		else $error("Standby oscillator wrong");
	reset_wake_a: assert property (o_sleeping && rst_any |=> o_reset_vector && !o_cpu_hold)
		else $error("Reset did not wake to vector");
	always_on_a: assert property (o_wdt_run == i_wdt_enable && o_bod_run == i_brownout_enable_fuse && o_adc_power == i_adc_enable)
		else $error("Always-on block dropped");
	comp_off_a: assert property (deep && $past(deep) && !i_comparator_uses_ref |-> !o_comparator_power)
		else $error("Comparator powered in deep sleep");
	inbuf_a: assert property (deep && $past(deep) |-> o_input_buf_en == i_wake_pin_needed)
		else $error("Input buffers wrong in deep sleep");
	// Main scenarios reached
	idle_c: cover property (go && i_mcu_control_reg[5] && md == MODE_IDLE);
	rv_c: cover property (o_sleeping && rst_any);
	deep_c: cover property (deep && $past(deep));
endmodule
bind sleep_mode_controller sleep_props i_props (.*);

// >>> core_side.sv
// Model of the core and one wake source beside the sleep controller.
// Assumes requests from the bench arrive as one-cycle pulses.
`timescale 1ns/10ps
module core_side (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_go,
	input wire logic i_wake,
	input wire logic i_cpu_hold,
	input wire logic i_irq_take,
	output logic o_sleep_instr,
	output logic o_irq_level
);
	// Core only executes an instruction while it is not held
	always_ff @(posedge i_clk) begin
		if (i_rst)
			o_sleep_instr <= 1'b0;
		else
			o_sleep_instr <= i_go & ~i_cpu_hold;
	end
	// Level source holds until the handler is entered, never less
	always_ff @(posedge i_clk) begin
		if (i_rst)
			o_irq_level <= 1'b0;
		else
			o_irq_level <= (o_irq_level | i_wake) & ~i_irq_take;
	end
endmodule

// >>> sleep_mode_controller_tb.sv
// Self-checking bench for the sleep controller: a mode table, then
// hand-written filter, reset and analog cases. Single 100 MHz clock.
`timescale 1ns/10ps
module sleep_mode_controller_tb;
	import sleep_pkg::*;
	// Mode row: control byte, crystal, expected sleep and clocks, wake span
	typedef struct {
		logic [7:0] ctrl;
		logic xtal;
		logic [5:0] ex;
		logic [7:0] lo;
		logic [7:0] hi;
	} row_t;
	logic i_clk, i_rst, i_sleep_instr, i_ext_crystal, i_async_timer_clock_select;
	logic i_global_irq_en, i_timer0_irq, i_timer0_irq_en, i_adc_done_irq;
	logic i_twi_match_irq, i_spm_ee_ready_irq, i_level_irq_pins_high;
	logic i_ext_irq_pins_low, i_other_irq, i_ext_reset, i_wdt_reset;
	logic i_bod_reset, i_adc_enable, i_comparator_disable_bit;
	logic i_comparator_uses_ref, i_wdt_enable, i_brownout_enable_fuse;
	logic i_wake_pin_needed, o_cpu_hold, o_cpu_clock_en, o_flash_clock_en;
	logic o_io_clock_en, o_converter_clock_en, o_async_clock_en, o_osc_en;
	logic o_adc_start, o_adc_extended, o_adc_power, o_comparator_power;
	logic o_vref_en, o_wdt_run, o_bod_run, o_input_buf_en, o_irq_take;
	logic o_reset_vector, o_sleeping, go, wake, adc_seen, rv_seen;
	logic [7:0] i_mcu_control_reg;
	logic [15:0] i_clock_select_fuses_cycles;
	int num_errors = 0;
	int total_checks = 0;
	int n;
	row_t r;
	// Start-up delay of 20 keeps deep wakes clearly above the standby span
	row_t rows[10] = '{
		'{8'h20, 1'b1, 6'h2F, 8'h04, 8'h14}, '{8'h28, 1'b1, 6'h27, 8'h04, 8'h14},
		'{8'h30, 1'b1, 6'h20, 8'h18, 8'h3C}, '{8'h38, 1'b1, 6'h22, 8'h18, 8'h3C},
		'{8'h24, 1'b1, 6'h1F, 8'h00, 8'h00}, '{8'h2C, 1'b1, 6'h1F, 8'h00, 8'h00},
		'{8'h34, 1'b1, 6'h21, 8'h04, 8'h07}, '{8'h3C, 1'b1, 6'h23, 8'h04, 8'h07},
		'{8'h34, 1'b0, 6'h1F, 8'h00, 8'h00}, '{8'h18, 1'b1, 6'h1F, 8'h00, 8'h00}};

	sleep_mode_controller i_dut (.*);
	core_side i_core (.i_clk(i_clk), .i_rst(i_rst), .i_go(go), .i_wake(wake),
		.i_cpu_hold(o_cpu_hold), .i_irq_take(o_irq_take),
		.o_sleep_instr(i_sleep_instr), .o_irq_level(i_twi_match_irq));

	// Free-running clock
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	// Catch one-cycle pulses so they are not missed between samples
	always @(posedge i_clk) begin
		if (o_adc_start === 1'b1) adc_seen <= 1'b1;
		if (o_reset_vector === 1'b1) rv_seen <= 1'b1;
	end

	task automatic finish_test;
		if (num_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask
	// Bounded wait for handler entry (irq high) or release of the hold
	task automatic wait_on(input bit irq, input logic v, output int c);
		logic s;
		c = 0;
		do begin
			@(posedge i_clk);
			#1;
			c++;
			s = irq ? o_irq_take : o_cpu_hold;
		end while (s !== v && c < 300);
		if (c >= 300) begin
			num_errors++;
			finish_test();
		end
	endtask
	// Ask the core to sleep with a given control byte, let it settle
	task automatic enter(input logic [7:0] c);
		@(posedge i_clk);
		i_mcu_control_reg <= c;
		adc_seen = 1'b0;
		go <= 1'b1;
		@(posedge i_clk);
		go <= 1'b0;
		repeat (3) @(posedge i_clk);
		#1;
	endtask
	task automatic irq_wake(output int c);
		@(posedge i_clk);
		wake <= 1'b1;
		@(posedge i_clk);
		wake <= 1'b0;
		wait_on(1'b1, 1'b1, c);
	endtask

	initial begin
		i_rst = 1'b1; i_mcu_control_reg = 8'h00; i_ext_crystal = 1'b1;
		i_clock_select_fuses_cycles = 16'h0014; i_async_timer_clock_select = 1'b1;
		i_global_irq_en = 1'b1; i_timer0_irq = 1'b0; i_timer0_irq_en = 1'b1;
		i_adc_done_irq = 1'b0; i_spm_ee_ready_irq = 1'b0; i_other_irq = 1'b0;
		i_level_irq_pins_high = 1'b0; i_ext_irq_pins_low = 1'b0;
		i_ext_reset = 1'b0; i_wdt_reset = 1'b0; i_bod_reset = 1'b0;
		i_adc_enable = 1'b1; i_comparator_disable_bit = 1'b0;
		i_comparator_uses_ref = 1'b0; i_wdt_enable = 1'b1;
		i_brownout_enable_fuse = 1'b1; i_wake_pin_needed = 1'b0;
		go = 1'b0; wake = 1'b0; adc_seen = 1'b0; rv_seen = 1'b0;
		repeat (20) @(posedge i_clk);
		i_rst <= 1'b0;
		// Mode table: entry, clock gating, then timed interrupt wake
		foreach (rows[k]) begin
			r = rows[k];
			i_ext_crystal <= r.xtal;
			enter(r.ctrl);
			chk("mode_clocks", {o_sleeping, o_cpu_clock_en, o_io_clock_en,
				o_converter_clock_en, o_async_clock_en, o_osc_en}, r.ex);
			chk("adc_start", adc_seen, r.ex[5] & r.ex[2]);
			if (r.ex[5]) begin
				chk("comparator", o_comparator_power, r.ex[3] | r.ex[2]);
				chk("in_buf", o_input_buf_en, r.ex[3] | r.ex[2]);
				irq_wake(n);
				chk("wake_min", n >= r.lo, 1'b1);
				chk("wake_max", n <= r.hi, 1'b1);
				wait_on(1'b0, 1'b0, n);
				chk("resume", n <= 3, 1'b1);
			end
		end
		// Power-down ignores unlisted sources, then a watchdog reset wakes
		enter(8'h30);
		{i_adc_done_irq, i_other_irq, i_timer0_irq, i_spm_ee_ready_irq} <= 4'hF;
		repeat (3) @(posedge i_clk);
		{i_adc_done_irq, i_other_irq, i_timer0_irq, i_spm_ee_ready_irq} <= 4'h0;
		#1;
		chk("pdown_filter", o_sleeping, 1'b1);
		rv_seen = 1'b0;
		i_wdt_reset <= 1'b1;
		@(posedge i_clk);
		i_wdt_reset <= 1'b0;
		repeat (2) @(posedge i_clk);
		#1;
		chk("reset_vector", {rv_seen, o_cpu_hold}, 2'h2);
		// Noise mode: other I/O stays asleep, memory-ready wakes
		enter(8'h28);
		i_other_irq <= 1'b1;
		repeat (3) @(posedge i_clk);
		i_other_irq <= 1'b0;
		#1;
		chk("noise_filter", o_sleeping, 1'b1);
		i_spm_ee_ready_irq <= 1'b1;
		wait_on(1'b1, 1'b1, n);
		i_spm_ee_ready_irq <= 1'b0;
		// Power-save with async timer: timer wake needs the global enable
		i_global_irq_en <= 1'b0;
		enter(8'h38);
		i_timer0_irq <= 1'b1;
		repeat (3) @(posedge i_clk);
		#1;
		chk("t0_gated", o_sleeping, 1'b1);
		i_global_irq_en <= 1'b1;
		wait_on(1'b1, 1'b1, n);
		i_timer0_irq <= 1'b0;
		// Reference follows its users; converter restart is extended
		@(posedge i_clk);
		{i_brownout_enable_fuse, i_adc_enable, i_comparator_disable_bit} <= 3'h1;
		repeat (3) @(posedge i_clk);
		#1;
		chk("vref_off", o_vref_en, 1'b0);
		chk("always_on", {o_adc_power, o_wdt_run, o_bod_run}, 3'h2);
		i_adc_enable <= 1'b1;
		repeat (3) @(posedge i_clk);
		#1;
		chk("vref_on", o_vref_en, 1'b1);
		chk("adc_ext", o_adc_extended, 1'b1);
		// Comparator on the reference and wake pins stay powered when deep
		{i_comparator_disable_bit, i_comparator_uses_ref,
			i_wake_pin_needed} <= 3'h3;
		enter(8'h30);
		chk("comp_ref", o_comparator_power, 1'b1);
		chk("wake_buf", o_input_buf_en, 1'b1);
		i_ext_irq_pins_low <= 1'b1;
		wait_on(1'b1, 1'b1, n);
		i_ext_irq_pins_low <= 1'b0;
		chk("low_wake", n <= 8'h3C, 1'b1);
		// Noise mode wakes on a high-group level source
		enter(8'h28);
		i_level_irq_pins_high <= 1'b1;
		wait_on(1'b1, 1'b1, n);
		i_level_irq_pins_high <= 1'b0;
		chk("level_wake", n <= 8'h14, 1'b1);
		// Reset in mid-sleep returns the hold, clock, analog and buffer outputs to their reset values
		enter(8'h30);
		i_rst <= 1'b1;
		@(posedge i_clk);
		i_rst <= 1'b0;
		#1;
		chk("reset_out", {o_cpu_hold, o_cpu_clock_en, o_flash_clock_en,
			o_io_clock_en, o_converter_clock_en, o_async_clock_en, o_osc_en,
			o_comparator_power, o_vref_en, o_input_buf_en}, 10'h1F9);
		finish_test();
	end
endmodule
